// [tdf_fetch.sv]
// transmit descriptor fetch engine with apb registers
// assumes host memory answers reads in order, data packed from the
// buffer's first byte, and a transmit fifo that never refuses a word
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "tdf_defs.svh"

// Operation
// RL1: software writes descriptors, then advances tail
// RL2: descriptors and buffers read from host memory
// RL3: packet starts only after all data fetched
// RL4: tail only advanced to end of packet
// RL5: any byte alignment, buffer up to 16 kB
// RL6: packet may span several descriptors
// RL7: segmentation of large buffers when requested
// RL8: 256 context sets, eight per queue
// RL9: context and data descriptors share one ring
// RL10: context descriptor loads context, no buffer
// RL11: type 2 loads context, type 3 uses it
// RL12: slot index picks one of queue's eight
// RL13: context governs up to two checksums
// RL14: segmentation part holds lengths and protocol
// RL15: segmentation fields dropped unless enabled; protocol type is kept regardless
// RL16: context stays until slot rewritten
// RL17: extension bit 29 clear means legacy
// RL18: type 2 context, 3 data, others reserved
// RL19: legacy layout: address, then length and fields
// RL20: software must supply address and length
// RL21: zero length legacy descriptor moves no data
// RL22: end of packet flag marks last descriptor
// RL23: ring order fetch, head wraps at ring end
module tdf_fetch #(
	parameter int unsigned QW = 5,
	parameter int unsigned LW = 18
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic mem_req_valid,
	output logic [63:0] mem_req_addr,
	output logic [15:0] mem_req_len,
	input wire logic mem_req_ready,
	input wire logic mem_rsp_valid,
	input wire logic [63:0] mem_rsp_data,
	input wire logic mem_rsp_last,
	output logic tx_fifo_valid,
	output logic [63:0] tx_fifo_data,
	output logic tx_go,
	output logic [LW-1:0] tx_pkt_len,
	output logic tx_legacy,
	output tdf_pkg::tdf_ctx_t tx_ctx
);
	import tdf_pkg::*;

	localparam int unsigned AW = QW + 3;

	// ****************************************************************
	// reset release
	// ****************************************************************
	logic rst_meta_r;
	logic rst_n_r;

	// runs regardless of ce so reset release never stalls
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end

	// ****************************************************************
	// declarations
	// ****************************************************************
	tdf_state_t st_r;
	logic en_r;
	logic [QW-1:0] queue_r;
	logic [63:0] base_r;
	logic [15:0] ring_len_r;
	logic [15:0] tail_r;
	logic [15:0] head_r;
	logic err_r;
	logic [15:0] pkt_cnt_r;
	logic [63:0] qw0_r;
	logic [63:0] qw1_r;
	logic beat_r;
	logic in_pkt_r;
	logic pkt_legacy_r;
	logic [LW-1:0] pkt_len_r;
	logic [31:0] rd_mux;
	logic hit;
	logic setup;
	logic wr_acc;
	logic descriptor_extension_flag;
	logic [3:0] descriptor_type_code;
	logic is_ctx;
	logic is_data;
	logic bad;
	logic eop;
	logic [15:0] buf_len;
	logic in_dec;
	logic buf_done;
	logic desc_done;
	logic [15:0] head_inc;

	tdf_ctx_if #(.AW(AW)) cif ();

	tdf_ctx_store #(
		.AW(AW),
		.DEPTH(2 ** AW)
	) u_store (
		.clk(clk),
		.ce(ce),
		.cif(cif.store)
	); // RL8

	// ****************************************************************
	// apb slave
	// ****************************************************************
	assign setup = psel & ~penable;
	assign wr_acc = psel & penable & pready & pwrite;

	always_comb begin
		rd_mux = 32'h0;
		hit = 1'b1;
		case (paddr)
			`TDF_OFF_CTRL: rd_mux = {19'h0, queue_r, 7'h0, en_r};
			`TDF_OFF_BASE_LO: rd_mux = base_r[31:0];
			`TDF_OFF_BASE_HI: rd_mux = base_r[63:32];
			`TDF_OFF_RING_LEN: rd_mux = {16'h0, ring_len_r};
			`TDF_OFF_TAIL: rd_mux = {16'h0, tail_r};
			`TDF_OFF_HEAD: rd_mux = {16'h0, head_r};
			`TDF_OFF_STATUS: rd_mux = {pkt_cnt_r, 14'h0,
				st_r != st_idle, err_r};
			default: hit = 1'b0;
		endcase
	end

	// one access cycle; answer is prepared during setup
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else if (ce) begin
			pready <= setup;
			pslverr <= setup & ~hit;
			prdata <= (setup & ~pwrite) ? rd_mux : 32'h0;
		end
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			en_r <= 1'b0;
			queue_r <= '0;
			base_r <= `TDF_RST_BASE;
			ring_len_r <= `TDF_RST_RING_LEN;
			tail_r <= 16'h0;
		end else if (ce && wr_acc) begin
			case (paddr)
				`TDF_OFF_CTRL: begin
					en_r <= pwdata[`TDF_CTRL_EN];
					queue_r <= pwdata[8 +: QW];
				end
				`TDF_OFF_BASE_LO: base_r[31:0] <= pwdata;
				`TDF_OFF_BASE_HI: base_r[63:32] <= pwdata;
				`TDF_OFF_RING_LEN: ring_len_r <= pwdata[15:0];
				`TDF_OFF_TAIL: tail_r <= pwdata[15:0]; // RL1 RL4
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// descriptor decode
	// ****************************************************************
	assign descriptor_extension_flag = qw1_r[`TDF_DESCRIPTOR_EXTENSION_FLAG_BIT]; // RL17
	assign descriptor_type_code = qw1_r[`TDF_DESCRIPTOR_TYPE_CODE_HI:`TDF_DESCRIPTOR_TYPE_CODE_LO];
	assign is_ctx = descriptor_extension_flag & (descriptor_type_code == `TDF_DESCRIPTOR_TYPE_CODE_CTX); // RL11 RL18
	assign is_data = ~descriptor_extension_flag | (descriptor_type_code == `TDF_DESCRIPTOR_TYPE_CODE_DATA); // RL11 RL18
	assign buf_len = qw1_r[`TDF_LEN_HI:`TDF_LEN_LO]; // RL19 RL20
	assign eop = qw1_r[`TDF_EOP_BIT]; // RL22
	// reserved types and oversize buffers are skipped and flagged
	assign bad = (descriptor_extension_flag & ~is_ctx & ~is_data) |
		(is_data & (buf_len > `TDF_MAX_BUF_LEN)); // RL5 RL18
	assign in_dec = (st_r == st_dec);
	assign buf_done = (st_r == st_bdat) & mem_rsp_valid & mem_rsp_last;
	assign desc_done = buf_done |
		(in_dec & (bad | is_ctx | (is_data & buf_len == 16'h0)));
	assign head_inc = (head_r == ring_len_r - 16'h1) ? 16'h0
		: head_r + 16'h1; // RL23

	// ****************************************************************
	// context store access
	// ****************************************************************
	assign cif.wr_en = in_dec & is_ctx; // RL9 RL10
	assign cif.wr_addr = {queue_r, qw1_r[`TDF_SLOT_HI:`TDF_SLOT_LO]}; // RL12
	assign cif.wr_data.seg_en = qw1_r[`TDF_SEG_EN_BIT]; // RL7
	assign cif.wr_data.maximum_segment_size = qw1_r[`TDF_SEG_EN_BIT]
		? qw1_r[`TDF_MSS_HI:`TDF_MSS_LO] : 16'h0; // RL14 RL15
	assign cif.wr_data.l4_len = qw1_r[`TDF_SEG_EN_BIT]
		? qw1_r[`TDF_L4_HI:`TDF_L4_LO] : 8'h0; // RL14 RL15
	// protocol type is kept whatever the segmentation enable says
	assign cif.wr_data.protocol_type_command = qw1_r[`TDF_PROTOCOL_TYPE_COMMAND_HI:`TDF_PROTOCOL_TYPE_COMMAND_LO]; // RL15
	assign cif.wr_data.vlan = qw0_r[`TDF_VLAN_HI:`TDF_VLAN_LO];
	assign cif.wr_data.mac_len = qw0_r[`TDF_MACLEN_HI:`TDF_MACLEN_LO]; // RL13
	assign cif.wr_data.ip_len = qw0_r[`TDF_IP_HEADER_LENGTH_HI:`TDF_IP_HEADER_LENGTH_LO]; // RL13
	// slot is taken from the first descriptor of a packet only
	assign cif.rd_en = in_dec & descriptor_extension_flag & is_data & ~bad & ~in_pkt_r; // RL11
	assign cif.rd_addr = {queue_r, qw1_r[`TDF_SLOT_HI:`TDF_SLOT_LO]}; // RL12

	// ****************************************************************
	// fetch sequencer
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			st_r <= st_idle;
			mem_req_valid <= 1'b0;
			mem_req_addr <= 64'h0;
			mem_req_len <= 16'h0;
			qw0_r <= 64'h0;
			qw1_r <= 64'h0;
			beat_r <= 1'b0;
		end else if (ce) begin
			unique case (st_r)
				st_idle: begin
					if (en_r && head_r != tail_r) begin // RL23
						mem_req_valid <= 1'b1;
						mem_req_addr <= base_r +
							{44'h0, head_r, 4'h0}; // RL2
						mem_req_len <= `TDF_DESC_BYTES;
						st_r <= st_dreq;
					end
				end
				st_dreq: begin
					if (mem_req_ready) begin
						mem_req_valid <= 1'b0;
						beat_r <= 1'b0;
						st_r <= st_drsp;
					end
				end
				st_drsp: begin
					if (mem_rsp_valid && !beat_r) begin
						qw0_r <= mem_rsp_data;
						beat_r <= 1'b1;
					end else if (mem_rsp_valid) begin
						qw1_r <= mem_rsp_data;
						st_r <= st_dec;
					end
				end
				st_dec: begin
					if (bad || is_ctx) begin
						st_r <= st_idle;
					end else if (buf_len == 16'h0) begin // RL21
						st_r <= (eop && in_pkt_r) ? st_go : st_idle;
					end else begin
						// any byte address is passed as is
						mem_req_valid <= 1'b1;
						mem_req_addr <= qw0_r; // RL2 RL5 RL19
						mem_req_len <= buf_len;
						st_r <= st_breq;
					end
				end
				st_breq: begin
					if (mem_req_ready) begin
						mem_req_valid <= 1'b0;
						st_r <= st_bdat;
					end
				end
				st_bdat: begin
					if (buf_done) begin
						st_r <= eop ? st_go : st_idle; // RL6 RL22
					end
				end
				st_go: st_r <= st_idle;
			endcase
		end
	end

	// ****************************************************************
	// ring head
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			head_r <= 16'h0;
		end else if (ce) begin
			if (!en_r && st_r == st_idle) begin
				head_r <= 16'h0;
			end else if (desc_done) begin
				head_r <= head_inc; // RL23
			end
		end
	end

	// ****************************************************************
	// error flag, set beats a same-cycle write-one clear
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			err_r <= 1'b0;
		end else if (ce) begin
			if (in_dec && bad) begin
				err_r <= 1'b1;
			end else if (wr_acc && paddr == `TDF_OFF_STATUS &&
				pwdata[`TDF_STAT_ERR]) begin
				err_r <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// packet assembly and start
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			tx_fifo_valid <= 1'b0;
			tx_fifo_data <= 64'h0;
		end else if (ce) begin
			tx_fifo_valid <= (st_r == st_bdat) & mem_rsp_valid;
			tx_fifo_data <= mem_rsp_data;
		end
	end

	// words already written to the fifo on a dropped packet stay there
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			in_pkt_r <= 1'b0;
			pkt_legacy_r <= 1'b0;
			pkt_len_r <= '0;
			pkt_cnt_r <= 16'h0;
			tx_go <= 1'b0;
			tx_pkt_len <= '0;
			tx_legacy <= 1'b0;
			tx_ctx <= '0;
		end else if (ce) begin
			tx_go <= 1'b0;
			if (in_dec && bad) begin
				in_pkt_r <= 1'b0;
				pkt_len_r <= '0;
			end else if (buf_done) begin
				pkt_len_r <= pkt_len_r + LW'(buf_len); // RL6
				in_pkt_r <= 1'b1;
				if (!in_pkt_r) begin
					pkt_legacy_r <= ~descriptor_extension_flag;
				end
			end else if (st_r == st_go) begin
				// every byte is already in the fifo here
				tx_go <= 1'b1; // RL3
				tx_pkt_len <= pkt_len_r;
				tx_legacy <= pkt_legacy_r;
				tx_ctx <= pkt_legacy_r ? '0 : cif.rd_data; // RL7 RL11
				in_pkt_r <= 1'b0;
				pkt_len_r <= '0;
				pkt_cnt_r <= pkt_cnt_r + 16'h1;
			end
		end
	end

endmodule

`default_nettype wire

// [tdf_defs.svh]
// offsets, field positions, reset values and fixed counts of the
// transmit descriptor fetch block; included by its bare name
`ifndef TDF_DEFS_SVH
`define TDF_DEFS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define TDF_OFF_CTRL 8'h00
`define TDF_OFF_BASE_LO 8'h04
`define TDF_OFF_BASE_HI 8'h08
`define TDF_OFF_RING_LEN 8'h0C
`define TDF_OFF_TAIL 8'h10
`define TDF_OFF_HEAD 8'h14
`define TDF_OFF_STATUS 8'h18

// ****************************************************************
// register fields and reset values
// ****************************************************************
`define TDF_CTRL_EN 0
`define TDF_STAT_ERR 0
`define TDF_STAT_BUSY 1
`define TDF_RST_RING_LEN 16'h0008
`define TDF_RST_BASE 64'h0000_0000_0000_0000

// ****************************************************************
// descriptor fields, second quadword unless noted
// ****************************************************************
`define TDF_LEN_HI 15
`define TDF_LEN_LO 0
`define TDF_EOP_BIT 24
`define TDF_DESCRIPTOR_EXTENSION_FLAG_BIT 29
`define TDF_SEG_EN_BIT 31
`define TDF_DESCRIPTOR_TYPE_CODE_HI 23
`define TDF_DESCRIPTOR_TYPE_CODE_LO 20
`define TDF_PROTOCOL_TYPE_COMMAND_HI 19
`define TDF_PROTOCOL_TYPE_COMMAND_LO 9
`define TDF_SLOT_HI 38
`define TDF_SLOT_LO 36
`define TDF_L4_HI 47
`define TDF_L4_LO 40
`define TDF_MSS_HI 63
`define TDF_MSS_LO 48
// first quadword of a context descriptor
`define TDF_IP_HEADER_LENGTH_HI 8
`define TDF_IP_HEADER_LENGTH_LO 0
`define TDF_MACLEN_HI 15
`define TDF_MACLEN_LO 9
`define TDF_VLAN_HI 31
`define TDF_VLAN_LO 16

// ****************************************************************
// codes and counts
// ****************************************************************
`define TDF_DESCRIPTOR_TYPE_CODE_CTX 4'h2
`define TDF_DESCRIPTOR_TYPE_CODE_DATA 4'h3
`define TDF_DESC_BYTES 16'h0010
`define TDF_MAX_BUF_LEN 16'h4000

`endif

// [tdf_pkg.sv]
// types shared by the descriptor fetch engine and its context store
// assumes nothing of its surroundings
package tdf_pkg;

	// one offload context: checksum part and segmentation part
	typedef struct packed {
		logic seg_en;
		logic [15:0] maximum_segment_size;
		logic [7:0] l4_len;
		logic [10:0] protocol_type_command;
		logic [15:0] vlan;
		logic [6:0] mac_len;
		logic [8:0] ip_len;
	} tdf_ctx_t;

	typedef enum logic [2:0] {
		st_idle = 3'b000,
		st_dreq = 3'b001,
		st_drsp = 3'b011,
		st_dec = 3'b010,
		st_breq = 3'b110,
		st_bdat = 3'b111,
		st_go = 3'b101
	} tdf_state_t;

endpackage

// [tdf_ctx_if.sv]
// write and read port of the on-chip offload context store
// assumes one clock shared by both ends
`timescale 1ns/100ps
`default_nettype none

interface tdf_ctx_if #(
	parameter int unsigned AW = 8
);
	logic wr_en;
	logic [AW-1:0] wr_addr;
	tdf_pkg::tdf_ctx_t wr_data;
	logic rd_en;
	logic [AW-1:0] rd_addr;
	tdf_pkg::tdf_ctx_t rd_data;

	modport store (
		input wr_en,
		input wr_addr,
		input wr_data,
		input rd_en,
		input rd_addr,
		output rd_data
	);
	modport user (
		output wr_en,
		output wr_addr,
		output wr_data,
		output rd_en,
		output rd_addr,
		input rd_data
	);
endinterface

`default_nettype wire

// [tdf_ctx_store.sv]
// context store: one set per slot, eight slots per queue
// assumes the user never reads and writes one slot in the same cycle
`timescale 1ns/100ps
`default_nettype none

module tdf_ctx_store #(
	parameter int unsigned AW = 8,
	parameter int unsigned DEPTH = 256
) (
	input wire logic clk,
	input wire logic ce,
	tdf_ctx_if.store cif
);
	import tdf_pkg::*;

	// no reset: a slot is meaningless until software loads it
	tdf_ctx_t mem [DEPTH];

	always_ff @(posedge clk) begin
		if (ce) begin
			if (cif.wr_en) begin
				mem[cif.wr_addr] <= cif.wr_data; // RL10
			end
			// read data holds until the next read
			if (cif.rd_en) begin
				cif.rd_data <= mem[cif.rd_addr]; // RL16
			end
		end
	end

endmodule

`default_nettype wire

// [tdf_fetch_chk.sv]
// assertions on the fetch engine top ports
// assumes the bind in the testbench top file
`timescale 1ns/100ps
`default_nettype none
module tdf_fetch_chk #(
	parameter int unsigned QW = 5,
	parameter int unsigned LW = 18
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic mem_req_valid,
	input wire logic [63:0] mem_req_addr,
	input wire logic [15:0] mem_req_len,
	input wire logic mem_req_ready,
	input wire logic mem_rsp_valid,
	input wire logic [63:0] mem_rsp_data,
	input wire logic mem_rsp_last,
	input wire logic tx_fifo_valid,
	input wire logic [63:0] tx_fifo_data,
	input wire logic tx_go,
	input wire logic [LW-1:0] tx_pkt_len,
	input wire logic tx_legacy,
	input wire tdf_pkg::tdf_ctx_t tx_ctx
);
	import tdf_pkg::*;
	// ****
	// one clock domain
	// ****
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);
	property p_apb;
		psel && !penable |=> pready ##1 !pready;
	endproperty
	a_apb: assert property (p_apb) else $error("apb answer");
	property p_hold;
		mem_req_valid && !mem_req_ready |=> mem_req_valid &&
			$stable(mem_req_addr) && $stable(mem_req_len);
	endproperty
	a_hold: assert property (p_hold) else $error("request moved");
	property p_drop;
		mem_req_valid && mem_req_ready |=> !mem_req_valid;
	endproperty
	a_drop: assert property (p_drop) else $error("request kept");
	property p_len;
		mem_req_valid |-> mem_req_len inside {[16'h0001:16'h4000]};
	endproperty
	a_len: assert property (p_len) else $error("read length");
	property p_beat;
		tx_fifo_valid |-> $past(mem_rsp_valid);
	endproperty
	a_beat: assert property (p_beat) else $error("beat unasked");
	property p_go;
		tx_go |=> !tx_go;
	endproperty
	a_go: assert property (p_go) else $error("go too long");
	property p_leg;
		tx_go && tx_legacy |-> tx_ctx == '0;
	endproperty
	a_leg: assert property (p_leg) else $error("legacy context");
	property p_seg;
		tx_go && !tx_ctx.seg_en |-> tx_ctx.maximum_segment_size == 16'h0000 &&
			tx_ctx.l4_len == 8'h00;
	endproperty
	a_seg: assert property (p_seg) else $error("seg fields kept");
endmodule
`default_nettype wire

// [tdf_hmem.sv]
// host memory model answering descriptor and buffer reads
// assumes one read outstanding; stalls at random
`timescale 1ns/100ps
`default_nettype none
module tdf_hmem (
	input wire logic clk,
	input wire logic mem_req_valid,
	input wire logic [63:0] mem_req_addr,
	input wire logic [15:0] mem_req_len,
	output logic mem_req_ready,
	output logic mem_rsp_valid,
	output logic [63:0] mem_rsp_data,
	output logic mem_rsp_last
);
	logic [7:0] mem [0:4095];
	initial begin
		int a, n, k;
		logic [63:0] w;
		for (int i = 0; i < 4096; i++) mem[i] = 8'(i * 7);
		mem_req_ready = 1'b0;
		mem_rsp_valid = 1'b0;
		mem_rsp_data = 64'h0;
		mem_rsp_last = 1'b0;
		forever begin
			@(posedge clk);
			if (mem_req_valid === 1'b1) begin
				a = int'(mem_req_addr[11:0]);
				n = int'(mem_req_len);
				repeat ($urandom % 3) @(posedge clk);
				mem_req_ready <= 1'b1;
				@(posedge clk);
				mem_req_ready <= 1'b0;
				repeat ($urandom % 3) @(posedge clk);
				// bytes packed from the buffer's first byte
				for (k = 0; k < (n + 7) / 8; k++) begin
					for (int j = 0; j < 8; j++) w[8*j +: 8] = mem[(a + 8*k + j) % 4096];
					mem_rsp_valid <= 1'b1;
					mem_rsp_data <= w;
					mem_rsp_last <= (k == (n + 7) / 8 - 1);
					@(posedge clk);
				end
				// released data never repeats the last beat
				mem_rsp_valid <= 1'b0;
				mem_rsp_last <= 1'b0;
				mem_rsp_data <= ~w;
			end
		end
	end
endmodule
`default_nettype wire

// [testbench.sv]
// self-checking bench for the descriptor fetch engine
// assumes the package, engine, memory model and checker compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import tdf_pkg::*;
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, perr;
	logic mrv, mrr, msv, msl, fv, go, leg, ce, ce_q;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [63:0] mra, msd, fd;
	logic [15:0] mrl;
	logic [17:0] plen;
	tdf_ctx_t ctx, pcx;
	tdf_ctx_t cx [0:255];
	tdf_ctx_t pq_ctx [$];
	logic [63:0] bq_d [$];
	int bq_n [$], pq_len [$], pq_leg [$];
	int err_count = 0, checks = 0, cyc = 0;
	int wp = 0, bp = 513, pl = 0, pleg = 0, npk = 0, q = 0, q1 = 0;
	tdf_fetch dut_u (.clk(clk), .rstn(rstn), .ce(ce), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mem_req_valid(mrv), .mem_req_addr(mra), .mem_req_len(mrl),
		.mem_req_ready(mrr), .mem_rsp_valid(msv), .mem_rsp_data(msd),
		.mem_rsp_last(msl), .tx_fifo_valid(fv), .tx_fifo_data(fd),
		.tx_go(go), .tx_pkt_len(plen), .tx_legacy(leg), .tx_ctx(ctx));
	tdf_hmem hm_u (.clk(clk), .mem_req_valid(mrv), .mem_req_addr(mra),
		.mem_req_len(mrl), .mem_req_ready(mrr), .mem_rsp_valid(msv),
		.mem_rsp_data(msd), .mem_rsp_last(msl));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic chk(input bit ok, input string m);
		checks++;
		if (!ok) begin
			err_count++;
			$display("FAIL %0t %s", $time, m);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// bytes past the buffer end are not the engine's to define
	function automatic logic [63:0] msk(input logic [63:0] d, input int n);
		for (int j = n; j < 8; j++) d[8*j +: 8] = 8'h00;
		return d;
	endfunction
	task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdat = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// t: 1 legacy, 2 context, 3 data, 0 reserved type
	task automatic dsc(input int t, input int n, input bit eop, input int s);
		logic [63:0] q0, q1w;
		tdf_ctx_t c;
		q0 = 64'(bp);
		// slot sits in 38:36 for data descriptors as for context ones
		q1w = {25'h0, 3'(s), 11'h0, eop, 8'h0, 16'(n)};
		q1w[29] = (t != 1);
		if (t != 1) q1w[23:20] = 4'(t);
		if (t == 2) begin
			c = 68'({$urandom, $urandom, $urandom});
			c.seg_en = n[0];
			q0 = {32'h0, c.vlan, c.mac_len, c.ip_len};
			q1w = {c.maximum_segment_size, c.l4_len, 1'b0, 3'(s), 4'h0, c.seg_en, 2'h1, 5'h0,
				4'h2, c.protocol_type_command, 9'h0};
			if (!c.seg_en) c.maximum_segment_size = 16'h0;
			if (!c.seg_en) c.l4_len = 8'h0;
			cx[q*8+s] = c;
		end
		for (int j = 0; j < 8; j++) hm_u.mem[wp*16+j] = q0[8*j +: 8];
		for (int j = 0; j < 8; j++) hm_u.mem[wp*16+8+j] = q1w[8*j +: 8];
		wp = (wp + 1) % 8;
		if (t == 0) pl = 0;
		if (t == 1 || t == 3) begin
			for (int j = 0; j < n; j++) hm_u.mem[bp+j] = 8'($urandom);
			for (int k = 0; k < n; k += 8) begin
				for (int j = 0; j < 8; j++) q0[8*j +: 8] = hm_u.mem[bp+k+j];
				bq_d.push_back(q0);
				bq_n.push_back(n - k);
			end
			if (pl == 0) pcx = '0;
			if (pl == 0 && t == 3) pcx = cx[q*8+s];
			if (pl == 0) pleg = (t == 1);
			pl += n;
			bp += n + 1 + $urandom % 4;
			if (eop && pl > 0) begin
				pq_len.push_back(pl);
				pq_leg.push_back(pleg);
				pq_ctx.push_back(pcx);
				pl = 0;
				npk++;
			end
		end
	endtask
	task automatic drain(input string nm);
		apb(1'b1, 8'h10, 32'(wp));
		// engine idle here, so a frozen engine must not start a fetch
		ce <= 1'b0;
		repeat (3 + $urandom % 4) @(posedge clk);
		chk(mrv === 1'b0, "frozen");
		ce <= 1'b1;
		for (int i = 0; i < 300; i++) begin
			apb(1'b0, 8'h14, 32'h0);
			if (rdat === 32'(wp) && pq_len.size() == 0) break;
		end
		repeat (4) @(posedge clk);
		chk(rdat === 32'(wp), "head");
		chk(bq_d.size() == 0 && pq_len.size() == 0, "missing output");
		$display("test %s done", nm);
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		ce_q <= ce;
		if (cyc == 30000) err_count++;
		if (cyc == 30000) conclude();
		if (ce_q && fv === 1'b1 && bq_d.size() > 0) begin
			chk(msk(fd, bq_n[0]) === msk(bq_d[0], bq_n[0]), "beat");
			void'(bq_d.pop_front());
			void'(bq_n.pop_front());
		end else if (ce_q && fv === 1'b1) chk(1'b0, "extra beat");
		if (ce_q && go === 1'b1 && pq_len.size() > 0) begin
			chk(plen === 18'(pq_len[0]), "length");
			chk(leg === 1'(pq_leg[0]) && ctx === pq_ctx[0], "context");
			void'(pq_len.pop_front());
			void'(pq_leg.pop_front());
			void'(pq_ctx.pop_front());
		end else if (ce_q && go === 1'b1) chk(1'b0, "extra packet");
	end
	initial begin
		int r;
		rstn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		r = $urandom(92);
		q = $urandom % 32;
		q1 = q;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		apb(1'b0, 8'h0C, 32'h0);
		chk(rdat === 32'h0000_0008, "ring length reset");
		apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
		chk(perr === 1'b1 && rdat === 32'h0, "unmapped");
		apb(1'b1, 8'h00, {19'h0, 5'(q), 7'h0, 1'b1});
		$display("test registers done");
		dsc(1, 13, 1, 0);
		drain("legacy");
		dsc(1, 5, 0, 0);
		dsc(1, 20, 1, 0);
		dsc(1, 0, 1, 0);
		drain("chain and null");
		dsc(2, 1, 0, 3);
		dsc(3, 1 + $urandom % 40, 1, 3);
		dsc(3, 1 + $urandom % 40, 1, 3);
		dsc(2, 0, 0, 5);
		dsc(3, 8, 1, 5);
		drain("contexts and wrap");
		q = (q1 + 1) % 32;
		apb(1'b1, 8'h00, {19'h0, 5'(q), 7'h0, 1'b1});
		dsc(2, 0, 0, 3);
		dsc(3, 8, 1, 3);
		drain("other queue");
		q = q1;
		apb(1'b1, 8'h00, {19'h0, 5'(q), 7'h0, 1'b1});
		dsc(3, 16, 1, 3);
		drain("queue kept");
		dsc(0, 0, 1, 0);
		drain("reserved");
		apb(1'b0, 8'h18, 32'h0);
		chk(rdat[0] === 1'b1 && rdat[31:16] === 16'(npk), "status");
		apb(1'b1, 8'h18, 32'h1);
		apb(1'b0, 8'h18, 32'h0);
		chk(rdat[0] === 1'b0, "error clear");
		conclude();
	end
endmodule
bind tdf_fetch tdf_fetch_chk #(.QW(QW), .LW(LW)) chk_u (.clk(clk),
	.rstn(rstn), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .mem_req_valid(mem_req_valid),
	.mem_req_addr(mem_req_addr), .mem_req_len(mem_req_len),
	.mem_req_ready(mem_req_ready), .mem_rsp_valid(mem_rsp_valid),
	.mem_rsp_data(mem_rsp_data), .mem_rsp_last(mem_rsp_last),
	.tx_fifo_valid(tx_fifo_valid), .tx_fifo_data(tx_fifo_data),
	.tx_go(tx_go), .tx_pkt_len(tx_pkt_len), .tx_legacy(tx_legacy),
	.tx_ctx(tx_ctx));
`default_nettype wire
